// *** common/keysense_pkg.sv ***
// Purpose: Shared constants for the key-sense port pair block
// Assumes: APB byte address is four times the register index
// Notes:   Registers are one byte wide in the low lane of a 32-bit word

package keysense_pkg;

	// ------------------------------------------------------------
	// Widths
	// ------------------------------------------------------------
	localparam int ADDR_W  = 18;
	localparam int DATA_W  = 32;
	localparam int BYTE_W  = 8;
	localparam int P7_PINS = 8;
	localparam int NB_PINS = 7;
	localparam int KS_PINS = 4;

	// ------------------------------------------------------------
	// Register indices and byte addresses
	// ------------------------------------------------------------
	localparam logic [15:0] IDX_P7_DIR    = 16'hFFBC;
	localparam logic [15:0] IDX_P7_LATCH  = 16'hFFBE;
	localparam logic [15:0] IDX_PULLUP    = 16'hFFF2;
	localparam logic [15:0] IDX_NB_DIR    = 16'hFFB9;
	localparam logic [15:0] IDX_NB_LATCH  = 16'hFFBB;
	localparam logic [15:0] IDX_REDIRECT  = 16'hFFF1;
	localparam logic [15:0] IDX_PERIPH    = 16'hFFF3;

	localparam logic [ADDR_W-1:0] ADDR_P7_DIR   = {IDX_P7_DIR, 2'b00};
	localparam logic [ADDR_W-1:0] ADDR_P7_LATCH = {IDX_P7_LATCH, 2'b00};
	localparam logic [ADDR_W-1:0] ADDR_PULLUP   = {IDX_PULLUP, 2'b00};
	localparam logic [ADDR_W-1:0] ADDR_NB_DIR   = {IDX_NB_DIR, 2'b00};
	localparam logic [ADDR_W-1:0] ADDR_NB_LATCH = {IDX_NB_LATCH, 2'b00};
	localparam logic [ADDR_W-1:0] ADDR_REDIRECT = {IDX_REDIRECT, 2'b00};
	localparam logic [ADDR_W-1:0] ADDR_PERIPH   = {IDX_PERIPH, 2'b00};

	// ------------------------------------------------------------
	// Reset and read values
	// ------------------------------------------------------------
	localparam logic [7:0] RST_P7_DIR   = 8'h00;
	localparam logic [7:0] RST_P7_LATCH = 8'h00;
	localparam logic [7:0] RST_PULLUP   = 8'h00;
	localparam logic [6:0] RST_NB_DIR   = 7'h00;
	localparam logic [6:0] RST_NB_LATCH = 7'h00;
	localparam logic [3:0] RST_REDIRECT = 4'hF;
	localparam logic [5:0] RST_PERIPH   = 6'h00;
	localparam logic [7:0] DIR_READ_ALL = 8'hFF;
	localparam logic [31:0] RD_ZERO     = 32'h0000_0000;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int PU_P7_LSB    = 4;
	localparam int PU_NB_LSB    = 0;
	localparam int REDIRECT_LSB = 4;
	localparam int PC_SYNC_EN   = 0;
	localparam int PC_OEA       = 1;
	localparam int PC_OEB       = 2;
	localparam int PC_EXTERNAL_INTERRUPT0_PIN_EN   = 3;
	localparam int PC_CKS_LSB   = 4;
	localparam logic [1:0] CKS_EXTERNAL = 2'h3;

	// Neighbour pin roles
	localparam int NB_EXT_CLK = 0;
	localparam int NB_CMP_A   = 1;
	localparam int NB_CMP_B   = 2;
	localparam int NB_SYNC_IN = 3;
	localparam int NB_EXTERNAL_INTERRUPT0_PIN    = 4;

endpackage

// *** core/gpio_pin_cell.sv ***
// Purpose: One port pin: direction, drive, readback and pull-up gating
// Assumes: Pin level is synchronous to the core clock
// Notes:   Purely combinational; the top registers every pin output

module gpio_pin_cell (
	// Software state
	input  wire logic dir,
	input  wire logic latch,
	input  wire logic pull_en,
	// Peripheral claim
	input  wire logic claim,
	input  wire logic claim_val,
	// Pin side
	input  wire logic pin_in,
	output logic      drive_oe,
	output logic      drive_val,
	output logic      read_val,
	output logic      pull_on
);

	// ------------------------------------------------------------
	// Drive
	// ------------------------------------------------------------
	assign drive_oe  = claim | dir;
	assign drive_val = claim ? claim_val : latch;

	// ------------------------------------------------------------
	// Readback
	// ------------------------------------------------------------
	// Latch wins for outputs so a loaded pin cannot corrupt a read-modify-write
	assign read_val = dir ? latch : pin_in;

	// ------------------------------------------------------------
	// Pull-up
	// ------------------------------------------------------------
	assign pull_on = ~dir & pull_en;

endmodule

// *** core/keysense_port_pair_io.sv ***
// Purpose: Port 7 GPIO plus lower pin functions of the neighbour port
// Assumes: APB slave, zero wait states, pins synchronous to CORE_CLK
// Notes:   Hardware standby clears state; software standby retains it
//
// Our own choice: the APB interface to the registers.

module keysense_port_pair_io (
	// Clock and reset
	input  wire logic        CORE_CLK,
	input  wire logic        ARST_N,
	// Standby control
	input  wire logic        HW_STANDBY,
	input  wire logic        SW_STANDBY,
	// APB slave
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [17:0] PADDR,
	input  wire logic [31:0] PWDATA,
	output logic      [31:0] PRDATA,
	output logic             PREADY,
	output logic             PSLVERR,
	// Port 7 pins
	input  wire logic [7:0]  P7_IN,
	output logic      [7:0]  P7_OUT,
	output logic      [7:0]  P7_OE,
	output logic      [3:0]  P7_PULLUP,
	// Neighbour port pins
	input  wire logic [6:0]  NB_IN,
	output logic      [6:0]  NB_OUT,
	output logic      [6:0]  NB_OE,
	output logic      [3:0]  NB_PULLUP,
	// Peripheral outputs claiming pins
	input  wire logic        TIMER_COMPARE_OUT_A,
	input  wire logic        TIMER_COMPARE_OUT_B,
	input  wire logic        SYNC_OUTPUT,
	// Peripheral inputs fed from pins
	output logic      [3:0]  KEYSENSE_INPUT,
	output logic             TIMER_CAPTURE_INPUT,
	output logic             SYNC_INPUT,
	output logic             TIMER_EXTERNAL_CLOCK_IN,
	output logic             EXTERNAL_INTERRUPT0_PIN_N
);

	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	logic [7:0]  port7_direction_r;
	logic [7:0]  port7_output_latch_r;
	logic [7:0]  keysense_pullup_control_r;
	logic [6:0]  neighbour_port_direction_r;
	logic [6:0]  neighbour_latch_r;
	logic [3:0]  keysense_redirect_select_r;
	logic [5:0]  periph_ctrl_r;

	logic [31:0] prdata_r;
	logic [31:0] prdata_nxt;
	logic        pready_r;
	logic        pslverr_r;
	logic        mapped;
	logic        setup_phase;
	logic        wr_take;
	logic [7:0]  wbyte;

	logic [7:0]  p7_oe_c;
	logic [7:0]  p7_val_c;
	logic [7:0]  p7_rd_c;
	logic [7:0]  p7_pu_c;
	logic [6:0]  nb_oe_c;
	logic [6:0]  nb_val_c;
	logic [6:0]  nb_rd_c;
	logic [6:0]  nb_pu_c;
	logic [6:0]  nb_claim;
	logic [6:0]  nb_claim_val;
	logic [6:0]  nb_read_src;
	logic [7:0]  nb_read_word;

	logic [7:0]  p7_out_r;
	logic [7:0]  p7_oe_r;
	logic [3:0]  p7_pullup_r;
	logic [6:0]  nb_out_r;
	logic [6:0]  nb_oe_r;
	logic [3:0]  nb_pullup_r;
	logic [3:0]  keysense_r;
	logic        capture_r;
	logic        sync_in_r;
	logic        ext_clk_r;
	logic        external_interrupt0_pin_n_r;

	logic        sync_en;
	logic        compare_a_output_enable;
	logic        compare_b_output_enable;
	logic        external_interrupt0_pin_en;
	logic [1:0]  clk_sel;

	// ------------------------------------------------------------
	// Address decode
	// ------------------------------------------------------------
	function automatic logic hit(input logic [17:0] addr, input logic [17:0] target);
		hit = (addr == target);
	endfunction

	assign setup_phase = PSEL & ~PENABLE;
	assign wr_take     = PSEL & PENABLE & pready_r & PWRITE & ~HW_STANDBY;
	assign wbyte       = PWDATA[7:0];

	assign mapped = hit(PADDR, keysense_pkg::ADDR_P7_DIR)
		| hit(PADDR, keysense_pkg::ADDR_P7_LATCH)
		| hit(PADDR, keysense_pkg::ADDR_PULLUP)
		| hit(PADDR, keysense_pkg::ADDR_NB_DIR)
		| hit(PADDR, keysense_pkg::ADDR_NB_LATCH)
		| hit(PADDR, keysense_pkg::ADDR_REDIRECT)
		| hit(PADDR, keysense_pkg::ADDR_PERIPH);

	// ------------------------------------------------------------
	// Peripheral control fields
	// ------------------------------------------------------------
	// Software standby resets the peripherals, so their claims drop out
	assign sync_en = periph_ctrl_r[keysense_pkg::PC_SYNC_EN] & ~SW_STANDBY;
	assign compare_a_output_enable     = periph_ctrl_r[keysense_pkg::PC_OEA] & ~SW_STANDBY;
	assign compare_b_output_enable     = periph_ctrl_r[keysense_pkg::PC_OEB] & ~SW_STANDBY;
	assign external_interrupt0_pin_en = periph_ctrl_r[keysense_pkg::PC_EXTERNAL_INTERRUPT0_PIN_EN];
	assign clk_sel = periph_ctrl_r[keysense_pkg::PC_CKS_LSB +: 2];

	// ------------------------------------------------------------
	// Port 7 registers
	// ------------------------------------------------------------
	always_ff @(posedge CORE_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			port7_direction_r <= keysense_pkg::RST_P7_DIR;
		end else if (HW_STANDBY) begin
			port7_direction_r <= keysense_pkg::RST_P7_DIR;
		end else if (wr_take && hit(PADDR, keysense_pkg::ADDR_P7_DIR)) begin
			port7_direction_r <= wbyte;
		end
	end

	always_ff @(posedge CORE_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			port7_output_latch_r <= keysense_pkg::RST_P7_LATCH;
		end else if (HW_STANDBY) begin
			port7_output_latch_r <= keysense_pkg::RST_P7_LATCH;
		end else if (wr_take && hit(PADDR, keysense_pkg::ADDR_P7_LATCH)) begin
			port7_output_latch_r <= wbyte;
		end
	end

	always_ff @(posedge CORE_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			keysense_pullup_control_r <= keysense_pkg::RST_PULLUP;
		end else if (HW_STANDBY) begin
			keysense_pullup_control_r <= keysense_pkg::RST_PULLUP;
		end else if (wr_take && hit(PADDR, keysense_pkg::ADDR_PULLUP)) begin
			keysense_pullup_control_r <= wbyte;
		end
	end

	// ------------------------------------------------------------
	// Neighbour port registers
	// ------------------------------------------------------------
	always_ff @(posedge CORE_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			neighbour_port_direction_r <= keysense_pkg::RST_NB_DIR;
			neighbour_latch_r          <= keysense_pkg::RST_NB_LATCH;
		end else if (HW_STANDBY) begin
			neighbour_port_direction_r <= keysense_pkg::RST_NB_DIR;
			neighbour_latch_r          <= keysense_pkg::RST_NB_LATCH;
		end else if (wr_take) begin
			if (hit(PADDR, keysense_pkg::ADDR_NB_DIR)) begin
				neighbour_port_direction_r <= wbyte[6:0];
			end
			if (hit(PADDR, keysense_pkg::ADDR_NB_LATCH)) begin
				neighbour_latch_r <= wbyte[6:0];
			end
		end
	end

	always_ff @(posedge CORE_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			keysense_redirect_select_r <= keysense_pkg::RST_REDIRECT;
			periph_ctrl_r              <= keysense_pkg::RST_PERIPH;
		end else if (HW_STANDBY) begin
			keysense_redirect_select_r <= keysense_pkg::RST_REDIRECT;
			periph_ctrl_r              <= keysense_pkg::RST_PERIPH;
		end else if (wr_take) begin
			if (hit(PADDR, keysense_pkg::ADDR_REDIRECT)) begin
				keysense_redirect_select_r <= wbyte[keysense_pkg::REDIRECT_LSB +: 4];
			end
			if (hit(PADDR, keysense_pkg::ADDR_PERIPH)) begin
				periph_ctrl_r <= wbyte[5:0];
			end
		end
	end

	// ------------------------------------------------------------
	// Pin function claims on the neighbour port
	// ------------------------------------------------------------
	always_comb begin
		nb_claim     = '0;
		nb_claim_val = '0;
		if (sync_en) begin
			nb_claim[keysense_pkg::NB_CMP_B]     = 1'b1;
			nb_claim_val[keysense_pkg::NB_CMP_B] = SYNC_OUTPUT;
		end else if (compare_b_output_enable) begin
			nb_claim[keysense_pkg::NB_CMP_B]     = 1'b1;
			nb_claim_val[keysense_pkg::NB_CMP_B] = TIMER_COMPARE_OUT_B;
		end
		if (compare_a_output_enable) begin
			nb_claim[keysense_pkg::NB_CMP_A]     = 1'b1;
			nb_claim_val[keysense_pkg::NB_CMP_A] = TIMER_COMPARE_OUT_A;
		end
	end

	// Readback source: bits 4..6 may be steered to port 7 pins 0..2
	always_comb begin
		nb_read_src = NB_IN;
		for (int i = 0; i < 3; i++) begin
			if (!keysense_redirect_select_r[i]) begin
				nb_read_src[i + 4] = P7_IN[i];
			end
		end
	end

	// ------------------------------------------------------------
	// Pin cells
	// ------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < keysense_pkg::P7_PINS; g++) begin : g_p7
			logic pull_en_g;
			if (g < keysense_pkg::KS_PINS) begin : g_pu
				assign pull_en_g = keysense_pullup_control_r[keysense_pkg::PU_P7_LSB + g];
			end else begin : g_nopu
				assign pull_en_g = 1'b0;
			end
			gpio_pin_cell u_cell (
				.dir       (port7_direction_r[g]),
				.latch     (port7_output_latch_r[g]),
				.pull_en   (pull_en_g),
				.claim     (1'b0),
				.claim_val (1'b0),
				.pin_in    (P7_IN[g]),
				.drive_oe  (p7_oe_c[g]),
				.drive_val (p7_val_c[g]),
				.read_val  (p7_rd_c[g]),
				.pull_on   (p7_pu_c[g])
			);
		end
		for (g = 0; g < keysense_pkg::NB_PINS; g++) begin : g_nb
			logic pull_en_g;
			if (g < keysense_pkg::KS_PINS) begin : g_pu
				assign pull_en_g = keysense_pullup_control_r[keysense_pkg::PU_NB_LSB + g];
			end else begin : g_nopu
				assign pull_en_g = 1'b0;
			end
			gpio_pin_cell u_cell (
				.dir       (neighbour_port_direction_r[g]),
				.latch     (neighbour_latch_r[g]),
				.pull_en   (pull_en_g),
				.claim     (nb_claim[g]),
				.claim_val (nb_claim_val[g]),
				.pin_in    (nb_read_src[g]),
				.drive_oe  (nb_oe_c[g]),
				.drive_val (nb_val_c[g]),
				.read_val  (nb_rd_c[g]),
				.pull_on   (nb_pu_c[g])
			);
		end
	endgenerate

	// Top bit has no pin: one unless redirected to port 7 pin 3
	assign nb_read_word = {keysense_redirect_select_r[3] ? 1'b1 : P7_IN[3], nb_rd_c};

	// ------------------------------------------------------------
	// APB read mux and answer
	// ------------------------------------------------------------
	always_comb begin
		prdata_nxt = keysense_pkg::RD_ZERO;
		if (hit(PADDR, keysense_pkg::ADDR_P7_DIR)) begin
			prdata_nxt[7:0] = keysense_pkg::DIR_READ_ALL;
		end else if (hit(PADDR, keysense_pkg::ADDR_P7_LATCH)) begin
			prdata_nxt[7:0] = p7_rd_c;
		end else if (hit(PADDR, keysense_pkg::ADDR_PULLUP)) begin
			prdata_nxt[7:0] = keysense_pullup_control_r;
		end else if (hit(PADDR, keysense_pkg::ADDR_NB_DIR)) begin
			prdata_nxt[7:0] = keysense_pkg::DIR_READ_ALL;
		end else if (hit(PADDR, keysense_pkg::ADDR_NB_LATCH)) begin
			prdata_nxt[7:0] = nb_read_word;
		end else if (hit(PADDR, keysense_pkg::ADDR_REDIRECT)) begin
			prdata_nxt[7:4] = keysense_redirect_select_r;
		end else if (hit(PADDR, keysense_pkg::ADDR_PERIPH)) begin
			prdata_nxt[5:0] = periph_ctrl_r;
		end
	end

	// Answer in the first access cycle; data sampled at the setup edge
	always_ff @(posedge CORE_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			pready_r  <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r  <= keysense_pkg::RD_ZERO;
		end else begin
			pready_r  <= setup_phase;
			pslverr_r <= setup_phase & ~mapped;
			if (setup_phase && !PWRITE) begin
				prdata_r <= prdata_nxt;
			end
		end
	end

	// ------------------------------------------------------------
	// Pin and peripheral output registers
	// ------------------------------------------------------------
	always_ff @(posedge CORE_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			p7_out_r    <= '0;
			p7_oe_r     <= '0;
			p7_pullup_r <= '0;
			nb_out_r    <= '0;
			nb_oe_r     <= '0;
			nb_pullup_r <= '0;
		end else begin
			p7_out_r    <= p7_val_c;
			p7_oe_r     <= p7_oe_c;
			p7_pullup_r <= p7_pu_c[3:0];
			nb_out_r    <= nb_val_c;
			nb_oe_r     <= nb_oe_c;
			nb_pullup_r <= nb_pu_c[3:0];
		end
	end

	always_ff @(posedge CORE_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			keysense_r <= '0;
			capture_r  <= 1'b0;
			sync_in_r  <= 1'b0;
			ext_clk_r  <= 1'b0;
			external_interrupt0_pin_n_r   <= 1'b1;
		end else begin
			keysense_r <= NB_IN[3:0];
			capture_r  <= NB_IN[keysense_pkg::NB_SYNC_IN];
			sync_in_r  <= NB_IN[keysense_pkg::NB_SYNC_IN];
			// Held low when not selected so no stray edges reach the timer
			ext_clk_r  <= (clk_sel == keysense_pkg::CKS_EXTERNAL)
				& NB_IN[keysense_pkg::NB_EXT_CLK];
			// Disabled input reads inactive high
			external_interrupt0_pin_n_r   <= external_interrupt0_pin_en ? NB_IN[keysense_pkg::NB_EXTERNAL_INTERRUPT0_PIN] : 1'b1;
		end
	end

	// ------------------------------------------------------------
	// Port wiring
	// ------------------------------------------------------------
	assign PRDATA                    = prdata_r;
	assign PREADY                    = pready_r;
	assign PSLVERR                   = pslverr_r;
	assign P7_OUT                    = p7_out_r;
	assign P7_OE                     = p7_oe_r;
	assign P7_PULLUP                 = p7_pullup_r;
	assign NB_OUT                    = nb_out_r;
	assign NB_OE                     = nb_oe_r;
	assign NB_PULLUP                 = nb_pullup_r;
	assign KEYSENSE_INPUT            = keysense_r;
	assign TIMER_CAPTURE_INPUT       = capture_r;
	assign SYNC_INPUT                = sync_in_r;
	assign TIMER_EXTERNAL_CLOCK_IN   = ext_clk_r;
	assign EXTERNAL_INTERRUPT0_PIN_N = external_interrupt0_pin_n_r;

endmodule

// *** tb/keysense_monitor.sv ***
// Purpose: Concurrent checks on the key-sense port pair block ports
// Assumes: Registers answer with zero wait states
// Notes:   Latch read checks skip cycles right after a write or a standby clear

module keysense_monitor (
	// Clock and reset
	input wire logic        CORE_CLK,
	input wire logic        ARST_N,
	// Standby
	input wire logic        HW_STANDBY,
	input wire logic        SW_STANDBY,
	// APB
	input wire logic        PSEL,
	input wire logic        PENABLE,
	input wire logic        PWRITE,
	input wire logic [17:0] PADDR,
	input wire logic [31:0] PWDATA,
	input wire logic [31:0] PRDATA,
	input wire logic        PREADY,
	input wire logic        PSLVERR,
	// Pins
	input wire logic [7:0]  P7_IN,
	input wire logic [7:0]  P7_OUT,
	input wire logic [7:0]  P7_OE,
	input wire logic [3:0]  P7_PULLUP,
	input wire logic [6:0]  NB_IN,
	input wire logic [6:0]  NB_OUT,
	input wire logic [6:0]  NB_OE,
	input wire logic [3:0]  NB_PULLUP,
	// Peripherals
	input wire logic        TIMER_COMPARE_OUT_A,
	input wire logic        TIMER_COMPARE_OUT_B,
	input wire logic        SYNC_OUTPUT,
	input wire logic [3:0]  KEYSENSE_INPUT,
	input wire logic        TIMER_CAPTURE_INPUT,
	input wire logic        SYNC_INPUT,
	input wire logic        TIMER_EXTERNAL_CLOCK_IN,
	input wire logic        EXTERNAL_INTERRUPT0_PIN_N
);
	timeunit 1ns;
	timeprecision 1ps;

	// ------
	// Helpers
	// ------
	default clocking cb @(posedge CORE_CLK);
	endclocking
	default disable iff (!ARST_N);

	wire rd_setup = PSEL && !PENABLE && !PWRITE;
	wire wr_done  = PSEL && PENABLE && PWRITE && PREADY;
	wire lat_rd   = rd_setup && PADDR == keysense_pkg::ADDR_P7_LATCH && !HW_STANDBY;

	// ------
	// Assertions
	// ------
	AST_DIR_READS_ONES:
	assert property (rd_setup && PADDR == keysense_pkg::ADDR_P7_DIR |=> PRDATA == 32'h0000_00FF)
		else $error("direction read not all ones");
	AST_READ_OUTPUT_BITS:
	assert property (lat_rd && !$past(wr_done) && !$past(HW_STANDBY)
		|=> ((PRDATA[7:0] ^ $past(P7_OUT)) & $past(P7_OE)) == 8'h00)
		else $error("output bit read not the latch");
	AST_READ_INPUT_BITS:
	assert property (lat_rd && !$past(wr_done) && !$past(HW_STANDBY)
		|=> ((PRDATA[7:0] ^ $past(P7_IN)) & ~$past(P7_OE)) == 8'h00)
		else $error("input bit read not the pin");
	AST_DIR_DRIVES_OE:
	assert property (wr_done && PADDR == keysense_pkg::ADDR_P7_DIR && !HW_STANDBY
		|=> ##1 ($past(HW_STANDBY) || P7_OE == $past(PWDATA[7:0], 2)))
		else $error("pin enables do not follow direction write");
	AST_HW_CLEARS:
	assert property (HW_STANDBY |=> ##1 (P7_OE == 8'h00 && P7_OUT == 8'h00 && P7_PULLUP == 4'h0))
		else $error("hardware standby did not clear port");
	AST_SW_HOLDS_OE:
	assert property (SW_STANDBY && !$past(wr_done, 2) && !$past(HW_STANDBY, 2) |-> $stable(P7_OE))
		else $error("pin enables moved in software standby");
	AST_PULLUP_INPUT_ONLY:
	assert property ((P7_PULLUP & P7_OE[3:0]) == 4'h0)
		else $error("pull-up on an output pin");
	AST_KEYSENSE_FOLLOWS:
	assert property ($past(ARST_N) && !$past(HW_STANDBY) |-> KEYSENSE_INPUT == $past(NB_IN[3:0]))
		else $error("key-sense inputs do not follow pins");
	AST_CAPTURE_SYNC_FED:
	assert property (TIMER_CAPTURE_INPUT == KEYSENSE_INPUT[3] && SYNC_INPUT == KEYSENSE_INPUT[3])
		else $error("capture or sync input not fed from pin 3");
	AST_EXTCLK_GATED:
	assert property (TIMER_EXTERNAL_CLOCK_IN |-> KEYSENSE_INPUT[0])
		else $error("external timer clock without pin level");
	AST_EXTERNAL_INTERRUPT0_PIN_GATED:
	assert property ($fell(EXTERNAL_INTERRUPT0_PIN_N) |-> !$past(NB_IN[4]))
		else $error("interrupt 0 fell while pin high");
endmodule

bind keysense_port_pair_io keysense_monitor mon (.*);

// *** tb/keysense_pin_model.sv ***
// Purpose: Board-side model of the port 7 and neighbour pins
// Assumes: External drivers win over pull-ups, block drive wins over all
// Notes:   Floating lines toggle so a stale level is never mistaken

module keysense_pin_model (
	// Clock
	input  wire logic        clk,
	// Drive from the block
	input  wire logic [7:0]  p7_out,
	input  wire logic [7:0]  p7_oe,
	input  wire logic [3:0]  p7_pull,
	input  wire logic [6:0]  nb_out,
	input  wire logic [6:0]  nb_oe,
	input  wire logic [3:0]  nb_pull,
	// External drivers
	input  wire logic [14:0] ext_en,
	input  wire logic [14:0] ext_val,
	// Pin levels
	output logic      [7:0]  p7_in,
	output logic      [6:0]  nb_in
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [14:0] float_r = 15'h2AAA;
	logic [14:0] lvl;
	logic [14:0] oe;
	logic [14:0] out;
	logic [14:0] pull;

	always_ff @(posedge clk) begin
		float_r <= ~float_r;
	end

	always_comb begin
		oe = {nb_oe, p7_oe};
		out = {nb_out, p7_out};
		pull = {3'h0, nb_pull, 4'h0, p7_pull};
		for (int i = 0; i < 15; i++)
			lvl[i] = oe[i] ? out[i] : (ext_en[i] ? ext_val[i] : (pull[i] | float_r[i]));
		p7_in = lvl[7:0];
		nb_in = lvl[14:8];
	end
endmodule

// *** tb/keysense_port_pair_io_tb.sv ***
// Purpose: Self-checking bench for the key-sense port pair block
// Assumes: Zero-wait APB slave, board modelled by keysense_pin_model
// Notes:   Bus results are queued by the driver and scored by a watcher

module keysense_port_pair_io_tb;
	timeunit 1ns;
	timeprecision 1ps;

	// ------
	// Signals
	// ------
	logic        CORE_CLK, ARST_N, HW_STANDBY, SW_STANDBY;
	logic        PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
	logic [17:0] PADDR;
	logic [31:0] PWDATA, PRDATA;
	logic [7:0]  P7_IN, P7_OUT, P7_OE;
	logic [6:0]  NB_IN, NB_OUT, NB_OE;
	logic [3:0]  P7_PULLUP, NB_PULLUP, KEYSENSE_INPUT;
	logic        TIMER_COMPARE_OUT_A, TIMER_COMPARE_OUT_B, SYNC_OUTPUT;
	logic        TIMER_CAPTURE_INPUT, SYNC_INPUT, TIMER_EXTERNAL_CLOCK_IN;
	logic        EXTERNAL_INTERRUPT0_PIN_N;
	logic [14:0] ext_en, ext_val;
	logic [7:0]  dir, lat, pu, pc;
	logic [6:0]  ndir, nlat;
	logic [3:0]  rsel;
	logic        sw;
	logic [31:0] rnd;
	logic [33:0] exp_q[$];
	int          n_fail, check_count;
	int          seed = 32'hAA54_FF93;

	keysense_port_pair_io uut (.*);
	keysense_pin_model pins (
		.clk     (CORE_CLK),
		.p7_out  (P7_OUT),
		.p7_oe   (P7_OE),
		.p7_pull (P7_PULLUP),
		.nb_out  (NB_OUT),
		.nb_oe   (NB_OE),
		.nb_pull (NB_PULLUP),
		.ext_en  (ext_en),
		.ext_val (ext_val),
		.p7_in   (P7_IN),
		.nb_in   (NB_IN)
	);

	// ------
	// Tasks
	// ------
	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		check_count++;
		if (seen !== want) begin
			n_fail++;
			$display("CHECK FAILED at %0t seen %h expected %h", $time, seen, want);
		end
	endtask

	task automatic apb(input logic w, input logic [17:0] a, input logic [7:0] d,
			input logic err, input logic [31:0] rd);
		exp_q.push_back({w, err, rd});
		PSEL <= 1'b1;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= {24'h00_0000, d};
		@(posedge CORE_CLK);
		PENABLE <= 1'b1;
		// No local limit: only the watchdog may end a stuck wait
		do begin
			@(posedge CORE_CLK);
		end while (PREADY !== 1'b1);
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
		@(posedge CORE_CLK);
	endtask

	task automatic wr(input logic [17:0] a, input logic [7:0] d);
		apb(1'b1, a, d, 1'b0, 32'h0000_0000);
	endtask

	task automatic rd(input logic [17:0] a, input logic [31:0] e);
		apb(1'b0, a, 8'h00, 1'b0, e);
	endtask

	task automatic verify();
		logic [7:0] p7l, nrd;
		logic [6:0] noe, nout, nbl;
		logic       cla, clb, cls;
		// Standby drops every peripheral claim
		cls = pc[0] & ~sw;
		cla = pc[1] & ~sw;
		clb = pc[2] & ~sw;
		repeat (3) @(posedge CORE_CLK);
		#1;
		for (int i = 0; i < 8; i++)
			p7l[i] = dir[i] ? lat[i] : (ext_en[i] ? ext_val[i] : 1'b1);
		noe = ndir | {4'h0, cls | clb, cla, 1'b0};
		nout = {nlat[6:3], cls ? SYNC_OUTPUT : (clb ? TIMER_COMPARE_OUT_B : nlat[2]),
			cla ? TIMER_COMPARE_OUT_A : nlat[1], nlat[0]};
		for (int i = 0; i < 7; i++) begin
			nbl[i] = noe[i] ? nout[i] : (ext_en[8 + i] ? ext_val[8 + i] : 1'b1);
			nrd[i] = (ndir[i] || i < 4 || rsel[i % 4]) ? (ndir[i] ? nlat[i] : nbl[i]) : p7l[i % 4];
		end
		nrd[7] = rsel[3] ? 1'b1 : p7l[3];
		check(P7_OE, dir);
		check(P7_OUT & dir, lat & dir);
		check({P7_PULLUP, NB_PULLUP}, {pu[7:4] & ~dir[3:0], pu[3:0] & ~ndir[3:0]});
		check(NB_OE, noe);
		check(NB_OUT & noe, nout & noe);
		check({KEYSENSE_INPUT, TIMER_CAPTURE_INPUT, SYNC_INPUT}, {nbl[3:0], nbl[3], nbl[3]});
		check(TIMER_EXTERNAL_CLOCK_IN, pc[5:4] == 2'h3 && nbl[0]);
		check(EXTERNAL_INTERRUPT0_PIN_N, !pc[3] || nbl[4]);
		@(posedge CORE_CLK);
		rd(keysense_pkg::ADDR_P7_DIR, 32'h0000_00FF);
		rd(keysense_pkg::ADDR_NB_DIR, 32'h0000_00FF);
		rd(keysense_pkg::ADDR_P7_LATCH, {24'h00_0000, p7l});
		rd(keysense_pkg::ADDR_NB_LATCH, {24'h00_0000, nrd});
		rd(keysense_pkg::ADDR_PULLUP, {24'h00_0000, pu});
		rd(keysense_pkg::ADDR_REDIRECT, {24'h00_0000, rsel, 4'h0});
		rd(keysense_pkg::ADDR_PERIPH, {26'h000_0000, pc[5:0]});
		apb(1'b1, 18'h0_0010, 8'hA5, 1'b1, 32'h0000_0000);
		apb(1'b0, 18'h0_0010, 8'h00, 1'b1, 32'h0000_0000);
	endtask

	task automatic summarize();
		$display("Comparisons %0d, mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// ------
	// Processes
	// ------
	initial begin
		CORE_CLK = 1'b0;
		forever #4 CORE_CLK = ~CORE_CLK;
	end

	always @(posedge CORE_CLK) begin
		if (PSEL && PENABLE && PREADY === 1'b1 && exp_q.size() > 0) begin
			check(PSLVERR, exp_q[0][32]);
			if (!exp_q[0][33])
				check(PRDATA, exp_q[0][31:0]);
			void'(exp_q.pop_front());
		end
	end

	initial begin
		repeat (20000) @(posedge CORE_CLK);
		n_fail++;
		summarize();
	end

	initial begin
		{ARST_N, HW_STANDBY, SW_STANDBY, PSEL, PENABLE, PWRITE} = 6'h00;
		PADDR = 18'h0_0000;
		PWDATA = 32'h0000_0000;
		{TIMER_COMPARE_OUT_A, TIMER_COMPARE_OUT_B, SYNC_OUTPUT} = 3'h0;
		ext_en = 15'h7FFF;
		ext_val = 15'h0000;
		{dir, lat, pu, pc} = 32'h0000_0000;
		{ndir, nlat, sw} = 15'h0000;
		rsel = 4'hF;
		repeat (12) @(posedge CORE_CLK);
		ARST_N <= 1'b1;
		verify();
		for (int k = 0; k < 24; k++) begin
			rnd = $random(seed);
			{dir, lat, pu, pc} = rnd;
			rnd = $random(seed);
			{sw, ndir, nlat, rsel} = rnd[18:0];
			SW_STANDBY <= 1'b0;
			{TIMER_COMPARE_OUT_A, TIMER_COMPARE_OUT_B, SYNC_OUTPUT} <= rnd[21:19];
			wr(keysense_pkg::ADDR_P7_DIR, dir);
			wr(keysense_pkg::ADDR_P7_LATCH, lat);
			wr(keysense_pkg::ADDR_PULLUP, pu);
			wr(keysense_pkg::ADDR_NB_DIR, {1'b0, ndir});
			wr(keysense_pkg::ADDR_NB_LATCH, {1'b0, nlat});
			wr(keysense_pkg::ADDR_REDIRECT, {rsel, 4'h0});
			wr(keysense_pkg::ADDR_PERIPH, pc);
			rnd = $random(seed);
			// Undriven pins without a pull-up get an external driver
			ext_val <= rnd[14:0];
			ext_en <= rnd[29:15] | ~{3'h0, pu[3:0] & ~ndir[3:0], 4'h0, pu[7:4] & ~dir[3:0]};
			SW_STANDBY <= sw;
			verify();
		end
		sw = 1'b0;
		SW_STANDBY <= 1'b0;
		ext_en <= 15'h7FFF;
		HW_STANDBY <= 1'b1;
		repeat (3) @(posedge CORE_CLK);
		HW_STANDBY <= 1'b0;
		{dir, lat, pu, pc} = 32'h0000_0000;
		{ndir, nlat} = 14'h0000;
		rsel = 4'hF;
		verify();
		check(exp_q.size(), 32'h0000_0000);
		summarize();
	end
endmodule
